// [hdl/udt_defs.svh]
`ifndef UDT_DEFS_SVH
`define UDT_DEFS_SVH
// register byte addresses
`define UDT_OFF_CTRL 8'h00
`define UDT_OFF_MODE 8'h04
`define UDT_OFF_COUNT 8'h08
`define UDT_OFF_RELOAD 8'h0C
`define UDT_OFF_STATUS 8'h10
`define UDT_OFF_MASK 8'h14
// control fields
`define UDT_CTRL_RUN 0
`define UDT_CTRL_SRC 1
`define UDT_CTRL_CPRL 2
`define UDT_CTRL_TX_CLOCK_SELECT 3
`define UDT_CTRL_RCLK 4
// mode fields
`define UDT_MODE_DOWN_COUNT_ENABLE 0
// status fields
`define UDT_ST_OVF 0
`define UDT_ST_TOG 1
// reset values
`define UDT_RST_CTRL 5'h00
`define UDT_RST_COUNT 16'h0000
`define UDT_RST_RELOAD 16'h0000
`define UDT_RST_MASK 2'h0
// prescale for oscillator timer operation
`define UDT_PRESCALE 12
`define UDT_TOP 16'hFFFF
`endif

// [hdl/udt_pkg.sv]
package udt_pkg;
  typedef enum logic [1:0]
  {
    UDT_CAPTURE = 2'b00,
    UDT_RELOAD = 2'b01,
    UDT_BAUD = 2'b11
  } udt_mode_t;
endpackage

// [hdl/udt_timer.sv]
// Added by the designer: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "udt_defs.svh"
//
// Contract
// - The count is a 16-bit value of a low byte carrying into a high byte.
// - The source select picks the clock divided by 12 or the external count pin.
// - The count advances only while run control is set and holds otherwise.
// - Capture, auto-reload or baud mode is picked from the rx clock, tx clock and capture/reload bits.
// - With down counting disabled the auto-reload timer counts up and ignores the direction pin.
// - With the direction pin high the count goes up and passing FFFFh sets the overflow flag and interrupt; IRQ only rises here while mask bit 0 is set.
// - An up overflow in auto-reload mode loads the 16-bit reload value into the count; capture and baud modes load 0000h.
// - With the direction pin low the count goes down and underflow is count equal to reload.
// - An underflow sets the overflow flag and loads FFFFh.
// - The toggle flag inverts on every up/down overflow or underflow.
// - The toggle flag raises no interrupt and reads as a seventeenth count bit.
module udt_timer
  import udt_pkg::*;
#(
  parameter int PRESCALE = `UDT_PRESCALE
)
(
  // clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  // avalon-mm slave
  input wire logic [7:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // pins
  input wire logic EXTERNAL_COUNT_PIN,
  input wire logic DIRECTION_PIN,
  // interrupt
  output logic IRQ
);

  // the prescale counter is eight bits wide
  if (PRESCALE < 1 || PRESCALE > 255)
  begin : g_bad_prescale
    $error("prescale out of range");
  end

  localparam logic [15:0] RST_COUNT = `UDT_RST_COUNT;
  localparam logic [15:0] RST_RELOAD = `UDT_RST_RELOAD;

  ////////////////////////////////////////////////////////////////////
  logic [4:0] timer_control_reg;
  logic timer_mode_reg;
  logic [7:0] timer_low_byte;
  logic [7:0] timer_high_byte;
  logic [7:0] reload_low;
  logic [7:0] reload_high;
  logic overflow_flag;
  logic toggle_flag;
  logic [1:0] mask_reg;
  logic [7:0] presc_reg;
  logic pin_s1_reg;
  logic pin_s2_reg;
  logic pin_prev_reg;
  logic ack_reg;
  logic [31:0] rdata_reg;
  logic [8:0] since_tick_reg;

  logic run_control;
  logic count_source_select;
  logic down_count_enable;
  udt_mode_t mode;
  logic tick;
  logic fall;
  logic [15:0] count;
  logic [15:0] reload;
  logic up;
  logic ovf_up;
  logic unf_dn;
  logic wrap;
  logic [15:0] count_next;
  logic wr_hit;
  logic rd_hit;
  logic clr_status;
  logic count_wr;

  function automatic udt_mode_t udt_decode(input logic rclk, input logic tx_clock_select, input logic cprl);
    if (rclk || tx_clock_select)
      udt_decode = UDT_BAUD;
    else if (cprl)
      udt_decode = UDT_CAPTURE;
    else
      udt_decode = UDT_RELOAD;
  endfunction

  assign run_control = timer_control_reg[`UDT_CTRL_RUN];
  assign count_source_select = timer_control_reg[`UDT_CTRL_SRC];
  assign down_count_enable = timer_mode_reg;
  assign mode = udt_decode(timer_control_reg[`UDT_CTRL_RCLK], timer_control_reg[`UDT_CTRL_TX_CLOCK_SELECT],
    timer_control_reg[`UDT_CTRL_CPRL]);
  assign count = {timer_high_byte, timer_low_byte};
  assign reload = {reload_high, reload_low};

  ////////////////////////////////////////////////////////////////////
  // count input selection
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      pin_s1_reg <= 1'b0;
      pin_s2_reg <= 1'b0;
      pin_prev_reg <= 1'b0;
    end
    else
    begin
      pin_s1_reg <= EXTERNAL_COUNT_PIN;
      pin_s2_reg <= pin_s1_reg;
      pin_prev_reg <= pin_s2_reg;
    end
  end

  assign fall = pin_prev_reg && !pin_s2_reg;

  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
      presc_reg <= 8'h00;
    else if (!run_control || count_source_select || presc_reg == 8'(PRESCALE - 1))
      presc_reg <= 8'h00;
    else
      presc_reg <= presc_reg + 8'h01;
  end

  assign tick = run_control && (count_source_select ? fall : (presc_reg == 8'(PRESCALE - 1)));

  // cycles since the last count step, for the prescale checks
  always_ff @(posedge CLK)
  begin
    if (SYS_RST || tick || !run_control || count_source_select)
      since_tick_reg <= 9'h000;
    else if (since_tick_reg != 9'h1FF)
      since_tick_reg <= since_tick_reg + 9'h001;
  end

  ////////////////////////////////////////////////////////////////////
  // counting
  assign up = (mode != UDT_RELOAD) || !down_count_enable || DIRECTION_PIN;
  assign ovf_up = tick && up && (count == `UDT_TOP);
  assign unf_dn = tick && !up && (count == reload);
  assign wrap = ovf_up || unf_dn;

  always_comb
  begin
    count_next = count;
    if (ovf_up)
      count_next = (mode == UDT_RELOAD) ? reload : 16'h0000;
    else if (unf_dn)
      count_next = `UDT_TOP;
    else if (tick && up)
      count_next = count + 16'h0001;
    else if (tick)
      count_next = count - 16'h0001;
  end

  // writes land at the edge where waitrequest is low
  assign wr_hit = AVS_WRITE && ack_reg;
  assign rd_hit = AVS_READ && !ack_reg;
  assign clr_status = rd_hit && AVS_ADDRESS == `UDT_OFF_STATUS;
  assign count_wr = wr_hit && AVS_ADDRESS == `UDT_OFF_COUNT;

  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      timer_low_byte <= RST_COUNT[7:0];
      timer_high_byte <= RST_COUNT[15:8];
    end
    else if (wr_hit && AVS_ADDRESS == `UDT_OFF_COUNT)
    begin
      if (AVS_BYTEENABLE[0])
        timer_low_byte <= AVS_WRITEDATA[7:0];
      if (AVS_BYTEENABLE[1])
        timer_high_byte <= AVS_WRITEDATA[15:8];
    end
    else
    begin
      timer_low_byte <= count_next[7:0];
      timer_high_byte <= count_next[15:8];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // flags: set wins over clear-on-read
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
      overflow_flag <= 1'b0;
    else if (wrap)
      overflow_flag <= 1'b1;
    else if (clr_status)
      overflow_flag <= 1'b0;
  end

  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
      toggle_flag <= 1'b0;
    else if (wrap && mode == UDT_RELOAD && down_count_enable)
      toggle_flag <= !toggle_flag;
  end

  assign IRQ = overflow_flag && mask_reg[`UDT_ST_OVF];

  ////////////////////////////////////////////////////////////////////
  // register writes
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      timer_control_reg <= `UDT_RST_CTRL;
      timer_mode_reg <= 1'b0;
      reload_low <= RST_RELOAD[7:0];
      reload_high <= RST_RELOAD[15:8];
      mask_reg <= `UDT_RST_MASK;
    end
    else if (wr_hit && AVS_BYTEENABLE[0])
    begin
      case (AVS_ADDRESS)
        `UDT_OFF_CTRL: timer_control_reg <= AVS_WRITEDATA[4:0];
        `UDT_OFF_MODE: timer_mode_reg <= AVS_WRITEDATA[`UDT_MODE_DOWN_COUNT_ENABLE];
        `UDT_OFF_RELOAD: reload_low <= AVS_WRITEDATA[7:0];
        `UDT_OFF_MASK: mask_reg <= AVS_WRITEDATA[1:0];
        default: ;
      endcase
      if (AVS_ADDRESS == `UDT_OFF_RELOAD && AVS_BYTEENABLE[1])
        reload_high <= AVS_WRITEDATA[15:8];
    end
    else if (wr_hit && AVS_BYTEENABLE[1] && AVS_ADDRESS == `UDT_OFF_RELOAD)
      reload_high <= AVS_WRITEDATA[15:8];
  end

  ////////////////////////////////////////////////////////////////////
  // one wait state, read data registered
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
      ack_reg <= 1'b0;
    else
      ack_reg <= (AVS_READ || AVS_WRITE) && !ack_reg;
  end

  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
      rdata_reg <= 32'h00000000;
    else if (rd_hit)
    begin
      case (AVS_ADDRESS)
        `UDT_OFF_CTRL: rdata_reg <= {27'h0000000, timer_control_reg};
        `UDT_OFF_MODE: rdata_reg <= {31'h00000000, timer_mode_reg};
        `UDT_OFF_COUNT: rdata_reg <= {15'h0000, toggle_flag, count};
        `UDT_OFF_RELOAD: rdata_reg <= {16'h0000, reload};
        `UDT_OFF_STATUS: rdata_reg <= {30'h00000000, toggle_flag, overflow_flag};
        `UDT_OFF_MASK: rdata_reg <= {30'h00000000, mask_reg};
        default: rdata_reg <= 32'h00000000;
      endcase
    end
  end

  assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && !ack_reg;
  assign AVS_READDATA = rdata_reg;

  ////////////////////////////////////////////////////////////////////
  // checks
  a_hold_stopped: assert property (@(posedge CLK) disable iff (SYS_RST)
    !run_control && !(wr_hit && AVS_ADDRESS == `UDT_OFF_COUNT) |=> $stable(count))
    else $error("count moved while stopped");
  a_up_reload: assert property (@(posedge CLK) disable iff (SYS_RST)
    ovf_up && mode == UDT_RELOAD && !(wr_hit && AVS_ADDRESS == `UDT_OFF_COUNT) |=> count == $past(reload))
    else $error("no reload on overflow");
  a_down_top: assert property (@(posedge CLK) disable iff (SYS_RST)
    unf_dn && !(wr_hit && AVS_ADDRESS == `UDT_OFF_COUNT) |=> count == 16'hFFFF)
    else $error("no FFFF on underflow");
  a_flag_set: assert property (@(posedge CLK) disable iff (SYS_RST)
    wrap |=> overflow_flag)
    else $error("overflow flag missing");
  a_flag_hold: assert property (@(posedge CLK) disable iff (SYS_RST)
    overflow_flag && !clr_status |=> overflow_flag)
    else $error("overflow flag dropped");
  a_toggle_flip: assert property (@(posedge CLK) disable iff (SYS_RST)
    wrap && mode == UDT_RELOAD && down_count_enable |=> toggle_flag != $past(toggle_flag))
    else $error("toggle flag not inverted");
  a_up_ignore: assert property (@(posedge CLK) disable iff (SYS_RST)
    tick && !down_count_enable && count != 16'hFFFF && !(wr_hit && AVS_ADDRESS == `UDT_OFF_COUNT)
    |=> count == $past(count) + 16'h0001)
    else $error("not counting up");
  a_down_step: assert property (@(posedge CLK) disable iff (SYS_RST)
    tick && !up && count != reload && !(wr_hit && AVS_ADDRESS == `UDT_OFF_COUNT)
    |=> count == $past(count) - 16'h0001)
    else $error("not counting down");
  a_prescale: assert property (@(posedge CLK) disable iff (SYS_RST)
    tick && !count_source_select |-> since_tick_reg == 9'(PRESCALE - 1))
    else $error("prescale period wrong");
  a_irq_level: assert property (@(posedge CLK) disable iff (SYS_RST)
    toggle_flag && !overflow_flag |-> !IRQ)
    else $error("interrupt from wrong source");
  a_edge_count: assert property (@(posedge CLK) disable iff (SYS_RST)
    run_control && count_source_select && tick |-> $past(pin_s2_reg) && !pin_s2_reg)
    else $error("count without falling edge");
  a_prescale_due: assert property (@(posedge CLK) disable iff (SYS_RST)
    run_control && !count_source_select && since_tick_reg == 9'(PRESCALE - 1) |-> tick)
    else $error("prescale step missing");
  a_byte_carry: assert property (@(posedge CLK) disable iff (SYS_RST)
    tick && up && count[7:0] == 8'hFF && count != `UDT_TOP && !count_wr
    |=> timer_low_byte == 8'h00 && timer_high_byte == $past(timer_high_byte) + 8'h01)
    else $error("low byte did not carry");
  a_mode_baud: assert property (@(posedge CLK) disable iff (SYS_RST)
    (timer_control_reg[`UDT_CTRL_RCLK] || timer_control_reg[`UDT_CTRL_TX_CLOCK_SELECT]) |-> mode == UDT_BAUD)
    else $error("clock select not baud mode");
  a_dir_ignore: assert property (@(posedge CLK) disable iff (SYS_RST)
    tick && mode == UDT_RELOAD && !down_count_enable && !DIRECTION_PIN && count != `UDT_TOP && !count_wr
    |=> count == $past(count) + 16'h0001)
    else $error("direction pin steered up-only count");
  a_dn_flag: assert property (@(posedge CLK) disable iff (SYS_RST)
    unf_dn |=> overflow_flag)
    else $error("underflow did not set flag");
  a_toggle_quiet: assert property (@(posedge CLK) disable iff (SYS_RST)
    !(wrap && mode == UDT_RELOAD && down_count_enable) |=> toggle_flag == $past(toggle_flag))
    else $error("toggle flag moved without wrap");
  a_count_rdback: assert property (@(posedge CLK) disable iff (SYS_RST)
    rd_hit && AVS_ADDRESS == `UDT_OFF_COUNT |=> AVS_READDATA[16] == $past(toggle_flag))
    else $error("seventeenth bit wrong");
  a_flag_clear: assert property (@(posedge CLK) disable iff (SYS_RST)
    clr_status && !wrap |=> !overflow_flag)
    else $error("status read did not clear flag");
  a_status_read: assert property (@(posedge CLK) disable iff (SYS_RST)
    clr_status |=> AVS_READDATA[0] == $past(overflow_flag))
    else $error("status read lost flag");
  a_pin_count: assert property (@(posedge CLK) disable iff (SYS_RST)
    run_control && count_source_select && fall |-> tick)
    else $error("falling edge not counted");

endmodule // udt_timer
`default_nettype wire

// [tb/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "udt_defs.svh"
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin error_cnt++; $display("wrong value t=%0t got %h exp %h", $time, a, e); end end
module tb_top;
  import udt_pkg::*;
  typedef struct {logic [31:0] v; logic [31:0] m;} udt_exp_t;
  logic clk = 0, rst = 1, rd = 0, wr = 0, fire = 0, dir_up = 0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, last_rd;
  logic waitreq, irq, cpin, dpin;
  logic [15:0] r;
  logic [31:0] ctl_v [3] = '{32'h07, 32'h0B, 32'h13};
  int error_cnt = 0, total_checks = 0;
  udt_exp_t exp_q[$];
  udt_exp_t e;
  initial forever #12.5 clk = ~clk;
  udt_pin_src i_udt_pin_src (.clk(clk), .fire(fire), .dir_up(dir_up), .count_pin(cpin), .dir_pin(dpin));
  udt_timer i_udt_timer (.CLK(clk), .SYS_RST(rst), .AVS_ADDRESS(addr), .AVS_READ(rd),
    .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(4'hF), .AVS_READDATA(rdata),
    .AVS_WAITREQUEST(waitreq), .EXTERNAL_COUNT_PIN(cpin), .DIRECTION_PIN(dpin), .IRQ(irq));
  ////////////////////////////////////////////////////////////////
  task automatic ack();
    do @(posedge clk); while (waitreq !== 1'b0);
  endtask
  task automatic bwr(input logic [7:0] a, input logic [31:0] d);
    addr <= a; wdata <= d; wr <= 1'b1; ack(); wr <= 1'b0; @(posedge clk);
  endtask
  task automatic brd(input logic [7:0] a, input logic [31:0] v, input logic [31:0] m = 32'h0001FFFF);
    exp_q.push_back('{v, m}); addr <= a; rd <= 1'b1; ack(); rd <= 1'b0; @(posedge clk);
  endtask
  task automatic pulse(input int n);
    repeat (n)
    begin
      fire <= 1'b1; @(posedge clk); fire <= 1'b0; repeat (8) @(posedge clk);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  always @(posedge clk)
  begin
    if (rd && waitreq === 1'b0)
    begin
      e = exp_q.pop_front();
      last_rd = rdata;
      `CHK(rdata & e.m, e.v & e.m)
    end
  end
  initial
  begin
    #(25ns * 20000); error_cnt++; wrap_up();
  end
  initial
  begin
    void'($urandom(42));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    brd(`UDT_OFF_CTRL, 32'(`UDT_RST_CTRL), 32'hFF);
    brd(`UDT_OFF_COUNT, 32'(`UDT_RST_COUNT));
    brd(`UDT_OFF_RELOAD, 32'(`UDT_RST_RELOAD), 32'hFFFF);
    brd(`UDT_OFF_MASK, 32'(`UDT_RST_MASK), 32'h3);
    brd(8'h18, 32'h0, 32'hFFFFFFFF);
    // up-only reload, direction pin low must not matter
    r = 16'($urandom % 32'hFFF0) + 16'h0010;
    bwr(`UDT_OFF_RELOAD, {16'h0, r}); bwr(`UDT_OFF_COUNT, 32'hFFFE); bwr(`UDT_OFF_MASK, 32'h1);
    bwr(`UDT_OFF_CTRL, 32'h3);
    pulse(1); repeat (4) @(posedge clk);
    brd(`UDT_OFF_COUNT, 32'h0FFFF);
    `CHK(irq, 1'b0)
    pulse(1); repeat (4) @(posedge clk);
    brd(`UDT_OFF_COUNT, {16'h0, r});
    `CHK(irq, 1'b1)
    brd(`UDT_OFF_STATUS, 32'h1, 32'h3);
    `CHK(irq, 1'b0)
    brd(`UDT_OFF_STATUS, 32'h0, 32'h3);
    // run cleared holds the count
    bwr(`UDT_OFF_CTRL, 32'h2); pulse(2);
    brd(`UDT_OFF_COUNT, {16'h0, r});
    // up/down mode, counting down to underflow
    bwr(`UDT_OFF_MASK, 32'h0); bwr(`UDT_OFF_COUNT, {16'h0, r + 16'h1});
    bwr(`UDT_OFF_MODE, 32'h1); bwr(`UDT_OFF_CTRL, 32'h3);
    pulse(1); repeat (4) @(posedge clk);
    brd(`UDT_OFF_COUNT, {16'h0, r});
    pulse(1); repeat (4) @(posedge clk);
    brd(`UDT_OFF_COUNT, 32'h1FFFF);
    `CHK(irq, 1'b0)
    bwr(`UDT_OFF_MASK, 32'h1);
    `CHK(irq, 1'b1)
    brd(`UDT_OFF_STATUS, 32'h3, 32'h3);
    dir_up <= 1'b1;
    pulse(1); repeat (4) @(posedge clk);
    brd(`UDT_OFF_COUNT, {16'h0, r});
    brd(`UDT_OFF_STATUS, 32'h1, 32'h3);
    // oscillator timing, pin ignored
    bwr(`UDT_OFF_MODE, 32'h0); bwr(`UDT_OFF_COUNT, 32'h0); bwr(`UDT_OFF_CTRL, 32'h1);
    // the stop write lands two edges after the wait, one edge ran before it: 42 cycles ran
    fork pulse(3); repeat (39) @(posedge clk); join
    bwr(`UDT_OFF_CTRL, 32'h0);
    brd(`UDT_OFF_COUNT, 32'((39 + 3) / `UDT_PRESCALE), 32'hFFFF);
    `CHK(last_rd[31:17], 15'h0000)
    // capture and baud modes just wrap
    bwr(`UDT_OFF_MASK, 32'h0);
    foreach (ctl_v[i])
    begin
      bwr(`UDT_OFF_COUNT, 32'hFFFF); bwr(`UDT_OFF_CTRL, ctl_v[i]);
      brd(`UDT_OFF_CTRL, ctl_v[i], 32'h1F);
      pulse(1); repeat (4) @(posedge clk);
      brd(`UDT_OFF_COUNT, 32'h0, 32'hFFFF);
    end
    wrap_up();
  end
endmodule // tb_top
`default_nettype wire

// [tb/udt_pin_src.sv]
`timescale 1ns/1ps
`default_nettype none
module udt_pin_src
(
  // clock
  input wire logic clk,
  // requests from the bench
  input wire logic fire,
  input wire logic dir_up,
  // pins towards the timer
  output logic count_pin,
  output logic dir_pin
);
  logic [2:0] low_cnt = 3'h0;
  // one falling edge per request, pin low four cycles
  always_ff @(posedge clk)
  begin
    if (fire)
      low_cnt <= 3'h4;
    else if (low_cnt != 3'h0)
      low_cnt <= low_cnt - 3'h1;
  end
  assign count_pin = (low_cnt == 3'h0);
  assign dir_pin = dir_up;
endmodule // udt_pin_src
`default_nettype wire
